// [rtl/spc_fifo.sv]
/*
 * Synchronous FIFO with valid/ready on both sides and registered full and
 * empty. Assumes a single clock and a depth that is a power of two.
 */
`timescale 1ns/1ps
module spc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_ni,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);
  localparam logic [AW:0] CNT_ZERO = '0;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_ptr_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + (AW + 1)'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - (AW + 1)'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= AW'(wr_ptr_q + AW'(1));
      end
      if (pop) begin
        rd_ptr_q <= AW'(rd_ptr_q + AW'(1));
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      cnt_q <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      in_ready_o <= (cnt_d != CNT_FULL);
      out_valid_o <= (cnt_d != CNT_ZERO);
    end
  end

endmodule : spc_fifo

// [rtl/spc_pkg.sv]
/*
 * Constants for the serial master status, interrupt-enable and clock
 * prescaler block: register offsets, bit positions, reset values and
 * buffer sizes. Assumes an 8-bit special function register bus.
 */
package spc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam logic [7:0] ADDR_PRESCALER = 8'hD2;
  localparam logic [7:0] ADDR_STATUS = 8'hD3;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hD7;
  localparam logic [7:0] ADDR_TX_DATA = 8'hD4;
  localparam logic [7:0] ADDR_RX_DATA = 8'hD5;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and masks.
  localparam logic [7:0] RST_PRESCALER = 8'h04;
  localparam logic [7:0] RST_STATUS = 8'h02;
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] MASK_IRQ_ENABLE = 8'h0F;
  localparam logic [7:0] MASK_PRESCALER = 8'hFC;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Status and enable bit positions; enable bit n gates status bit n.
  localparam int BIT_RX_FULL = 0;
  localparam int BIT_TX_EMPTY = 1;
  localparam int BIT_RX_OVERRUN = 2;
  localparam int BIT_TX_END = 3;
  localparam int BIT_BUSY = 4;
  localparam int NUM_FLAGS = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: lowest weighted bit and its weight.
  localparam int PRESCALE_LSB = 2;
  localparam int PRESCALE_BITS = 6;
  localparam logic [7:0] PRESCALE_W4 = 8'h04;
  localparam logic [6:0] HALF_ONE = 7'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer.
  localparam int DATA_W = 8;
  localparam int RX_FIFO_DEPTH = 8;

endpackage : spc_pkg

// [rtl/spc_status_prescaler.sv]
/*
 * Status flags, interrupt enables, serial clock prescaler, transmit data
 * holding register and buffered receive data register of a serial master.
 * Assumes a shift engine outside that takes transmit bytes, returns
 * received bytes and reports transfer ends, and an 8-bit register bus
 * with one-cycle read and write strobes. The serial clock idles low, runs
 * only while a byte is in flight and keeps one half period for the whole
 * byte.
 */
`timescale 1ns/1ps
module spc_status_prescaler
  import spc_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  // Register bus
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_WDATA_I,
  output logic [7:0] SFR_RDATA_O,
  // Transmit side of the shift engine
  output logic [7:0] TX_DATA_O,
  output logic TX_VALID_O,
  input wire logic TX_TAKE_I,
  input wire logic XFER_DONE_I,
  // Receive side of the shift engine
  input wire logic RX_VALID_I,
  input wire logic [7:0] RX_DATA_I,
  output logic RX_READY_O,
  // Serial clock and interrupt
  output logic SCK_O,
  output logic SCK_EDGE_O,
  output logic IRQ_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [7:0] prescaler_q;
  logic [NUM_FLAGS-1:0] irq_en_q;
  logic tx_end_flag_q;
  logic rx_overrun_flag_q;
  logic tx_empty_flag_q;
  logic rx_full_flag_q;
  logic busy_q;
  logic [7:0] tx_data_reg_q;
  logic [7:0] rx_data_reg_q;

  logic wr_prescaler;
  logic wr_irq_en;
  logic wr_tx_data;
  logic rd_status;
  logic rd_rx_data;
  logic rx_overrun_evt;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic [NUM_FLAGS-1:0] flags;
  logic [7:0] status_val;
  logic [7:0] rdata_d;
  logic rx_load;
  logic [NUM_FLAGS-1:0] irq_src;

  assign wr_prescaler = SFR_WR_I && (SFR_ADDR_I == ADDR_PRESCALER);
  assign wr_irq_en = SFR_WR_I && (SFR_ADDR_I == ADDR_IRQ_ENABLE);
  assign wr_tx_data = SFR_WR_I && (SFR_ADDR_I == ADDR_TX_DATA);
  assign rd_status = SFR_RD_I && (SFR_ADDR_I == ADDR_STATUS);
  assign rd_rx_data = SFR_RD_I && (SFR_ADDR_I == ADDR_RX_DATA);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      irq_en_q <= RST_IRQ_ENABLE[NUM_FLAGS-1:0];
    end else if (wr_irq_en) begin
      irq_en_q <= SFR_WDATA_I[NUM_FLAGS-1:0];
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      prescaler_q <= RST_PRESCALER;
    end else if (wr_prescaler) begin
      prescaler_q <= SFR_WDATA_I & MASK_PRESCALER;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit holding register and its empty flag.
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tx_data_reg_q <= ZERO_BYTE;
    end else if (wr_tx_data) begin
      tx_data_reg_q <= SFR_WDATA_I;
    end
  end

  // A fresh write keeps the byte valid even when the old one is taken.
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      TX_VALID_O <= 1'b0;
    end else if (wr_tx_data) begin
      TX_VALID_O <= 1'b1;
    end else if (TX_TAKE_I) begin
      TX_VALID_O <= 1'b0;
    end
  end

  assign TX_DATA_O = tx_data_reg_q;

  // A load in the same cycle as a write wins, so the flag reads set.
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tx_empty_flag_q <= RST_STATUS[BIT_TX_EMPTY];
    end else if (TX_TAKE_I && TX_VALID_O) begin
      tx_empty_flag_q <= 1'b1;
    end else if (wr_tx_data) begin
      tx_empty_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Busy and transmission end.
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      busy_q <= RST_STATUS[BIT_BUSY];
    end else if (TX_TAKE_I && TX_VALID_O) begin
      busy_q <= 1'b1;
    end else if (XFER_DONE_I) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tx_end_flag_q <= RST_STATUS[BIT_TX_END];
    end else if (XFER_DONE_I) begin
      tx_end_flag_q <= 1'b1;
    end else if (rd_status) begin
      tx_end_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive path: buffer, data register, full and overrun flags.
  spc_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i(CORE_CLK_I),
    .rst_ni(RESETN_I),
    .in_valid_i(RX_VALID_I),
    .in_data_i(RX_DATA_I),
    .in_ready_o(RX_READY_O),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(!rx_full_flag_q)
  );

  // A byte offered while the receive buffer is full is lost, even if the data register is empty.
  assign rx_overrun_evt = RX_VALID_I && !RX_READY_O;
  // A buffered byte moves on only while the data register is empty: after reset or once it has been read.
  assign rx_load = fifo_out_valid && !rx_full_flag_q;

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rx_data_reg_q <= ZERO_BYTE;
    end else if (rx_load) begin
      rx_data_reg_q <= fifo_out_data;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rx_full_flag_q <= RST_STATUS[BIT_RX_FULL];
    end else if (rx_load) begin
      rx_full_flag_q <= 1'b1;
    end else if (rd_rx_data) begin
      rx_full_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rx_overrun_flag_q <= RST_STATUS[BIT_RX_OVERRUN];
    end else if (rx_overrun_evt) begin
      rx_overrun_flag_q <= 1'b1;
    end else if (rd_status) begin
      rx_overrun_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status byte and read data.
  always_comb begin
    flags = '0;
    flags[BIT_TX_END] = tx_end_flag_q;
    flags[BIT_RX_OVERRUN] = rx_overrun_flag_q;
    flags[BIT_TX_EMPTY] = tx_empty_flag_q;
    flags[BIT_RX_FULL] = rx_full_flag_q;
    status_val = ZERO_BYTE;
    status_val[NUM_FLAGS-1:0] = flags;
    status_val[BIT_BUSY] = busy_q;
  end

  always_comb begin
    case (SFR_ADDR_I)
      ADDR_PRESCALER: rdata_d = prescaler_q;
      ADDR_STATUS: rdata_d = status_val;
      ADDR_IRQ_ENABLE: rdata_d = {4'h0, irq_en_q};
      ADDR_TX_DATA: rdata_d = tx_data_reg_q;
      ADDR_RX_DATA: rdata_d = rx_data_reg_q;
      default: rdata_d = ZERO_BYTE;
    endcase
  end

  // The read data holds between reads, so a late sample still sees it.
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      SFR_RDATA_O <= ZERO_BYTE;
    end else if (SFR_RD_I) begin
      SFR_RDATA_O <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request: each flag gated by its own enable bit.
  for (genvar g = 0; g < NUM_FLAGS; g++) begin : g_irq_src
    assign irq_src[g] = flags[g] && irq_en_q[g];
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |irq_src;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock prescaler.
  logic [7:0] weight [PRESCALE_BITS];
  logic [7:0] divisor;
  logic [6:0] half_period;
  logic [6:0] div_cnt_q;
  logic [6:0] half_q;
  logic sck_run;
  logic sck_tick;

  for (genvar i = 0; i < PRESCALE_BITS; i++) begin : g_weight
    assign weight[i] = prescaler_q[PRESCALE_LSB + i] ? (PRESCALE_W4 << i) : ZERO_BYTE;
  end

  always_comb begin
    divisor = ZERO_BYTE;
    for (int k = 0; k < PRESCALE_BITS; k++) begin
      divisor = divisor + weight[k];
    end
    half_period = divisor[7:1];
  end

  // The half period is captured when a byte is loaded, so a prescaler write
  // during a byte cannot stretch or cut a clock phase.
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      half_q <= '0;
    end else if (TX_TAKE_I && TX_VALID_O) begin
      half_q <= half_period;
    end
  end

  // The clock runs only during a transfer and idles low; with no bit set
  // the divisor is zero and the clock is held.
  assign sck_run = busy_q && (half_q != '0);
  assign sck_tick = sck_run && (div_cnt_q >= half_q - HALF_ONE);

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      div_cnt_q <= '0;
    end else if (!sck_run || sck_tick) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + HALF_ONE;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      SCK_O <= 1'b0;
    end else if (!sck_run) begin
      SCK_O <= 1'b0;
    end else if (sck_tick) begin
      SCK_O <= !SCK_O;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      SCK_EDGE_O <= 1'b0;
    end else begin
      SCK_EDGE_O <= sck_tick;
    end
  end

endmodule : spc_status_prescaler

// [testbench/spc_slave_model.sv]
/* Shift engine and slave stand-in: takes a byte, counts 16 clock edges,
   answers with its inverse; flood_i offers a byte every cycle. */
`timescale 1ns/1ps
module spc_slave_model (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_ni,
  input wire logic flood_i,
  // Block side
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic sck_edge_i,
  input wire logic rx_ready_i,
  output logic tx_take_o,
  output logic done_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o
);
  logic busy_q;
  logic fl_q;
  logic [4:0] cnt_q;
  logic [7:0] sh_q;
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      {busy_q, fl_q, cnt_q, sh_q, tx_take_o, done_o, rx_valid_o} <= '0;
      rx_data_o <= 8'h5a;
    end else begin
      tx_take_o <= 1'b0;
      done_o <= 1'b0;
      fl_q <= flood_i;
      if (flood_i) begin
        rx_valid_o <= 1'b1;
        rx_data_o <= rx_data_o + 8'h01;
      end else if (rx_valid_o && (rx_ready_i || fl_q)) begin
        rx_valid_o <= 1'b0;
        rx_data_o <= ~rx_data_o;
      end
      if (!busy_q && tx_valid_i) begin
        tx_take_o <= 1'b1;
        busy_q <= 1'b1;
        cnt_q <= 5'h00;
        sh_q <= tx_data_i;
      end else if (busy_q && sck_edge_i) begin
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q == 5'h0f) begin
          busy_q <= 1'b0;
          done_o <= 1'b1;
          rx_valid_o <= 1'b1;
          rx_data_o <= ~sh_q;
        end
      end
    end
  end
endmodule : spc_slave_model

// [testbench/spc_sp_properties.sv]
/* Port checker for the serial status block.
   Assumes it is bound into spc_status_prescaler. */
`timescale 1ns/1ps
module spc_sp_properties
  import spc_pkg::*;
(
  // Clock, reset, bus
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic [7:0] SFR_RDATA_O,
  // Engine side
  input wire logic [7:0] TX_DATA_O,
  input wire logic TX_VALID_O,
  input wire logic TX_TAKE_I,
  input wire logic SCK_O,
  input wire logic SCK_EDGE_O,
  input wire logic IRQ_O
);
  logic [7:0] pre_q;
  logic [3:0] en_q;
  logic wr_tx;
  logic rd_pre;
  logic rd_en;
  assign wr_tx = SFR_WR_I && (SFR_ADDR_I == ADDR_TX_DATA);
  assign rd_pre = SFR_RD_I && (SFR_ADDR_I == ADDR_PRESCALER);
  assign rd_en = SFR_RD_I && (SFR_ADDR_I == ADDR_IRQ_ENABLE);
  // Shadows of the prescaler and interrupt-enable registers.
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pre_q <= RST_PRESCALER;
      en_q <= 4'h0;
    end else if (SFR_WR_I) begin
      if (SFR_ADDR_I == ADDR_PRESCALER) pre_q <= SFR_WDATA_I & MASK_PRESCALER;
      if (SFR_ADDR_I == ADDR_IRQ_ENABLE) en_q <= SFR_WDATA_I[3:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);
  sequence s_hi2;
    SCK_O ##1 SCK_O;
  endsequence
  property p_sck;
    $rose(SCK_O) |-> s_hi2;
  endproperty
  a_sck: assert property (p_sck) else $error("sck high too short");
  property p_edge;
    SCK_EDGE_O == $changed(SCK_O);
  endproperty
  a_edge: assert property (p_edge) else $error("serial clock edge pulse");
  property p_load;
    wr_tx |=> TX_VALID_O && (TX_DATA_O == $past(SFR_WDATA_I));
  endproperty
  a_load: assert property (p_load) else $error("tx load");
  property p_take;
    TX_VALID_O && TX_TAKE_I && !wr_tx |=> !TX_VALID_O;
  endproperty
  a_take: assert property (p_take) else $error("tx take");
  property p_pre;
    rd_pre |=> SFR_RDATA_O == $past(pre_q);
  endproperty
  a_pre: assert property (p_pre) else $error("prescaler read");
  property p_en;
    rd_en |=> SFR_RDATA_O == {4'h0, $past(en_q)};
  endproperty
  a_en: assert property (p_en) else $error("enable read");
  property p_unmap;
    SFR_RD_I && !(SFR_ADDR_I inside {[8'hD2 : 8'hD5], 8'hD7}) |=> SFR_RDATA_O == ZERO_BYTE;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_quiet;
    (en_q == 4'h0) && ($past(en_q) == 4'h0) |-> !IRQ_O;
  endproperty
  a_quiet: assert property (p_quiet) else $error("irq while masked");
  property p_txe;
    en_q[1] && $past(en_q[1]) && !TX_VALID_O && !$past(TX_VALID_O) && !$past(TX_VALID_O, 2)
      |-> IRQ_O;
  endproperty
  a_txe: assert property (p_txe) else $error("tx empty irq");
endmodule : spc_sp_properties

// [testbench/spc_status_prescaler_tb.sv]
/* Self-checking bench for spc_status_prescaler.
   Assumes the package, the slave model and the checker are compiled. */
`timescale 1ns/1ps
module spc_status_prescaler_tb;
  import spc_pkg::*;
  logic CORE_CLK_I = 1'b0;
  logic RESETN_I, SFR_WR_I, SFR_RD_I, flood, tend_m, ovr_m;
  logic [7:0] SFR_ADDR_I, SFR_WDATA_I, SFR_RDATA_O, TX_DATA_O, RX_DATA_I, pre_m, en_m, b;
  logic TX_VALID_O, TX_TAKE_I, XFER_DONE_I, RX_VALID_I, RX_READY_O, SCK_O, SCK_EDGE_O, IRQ_O;
  logic [31:0] seed = 32'h0000_e351;
  logic [7:0] rxq[$];
  int failures = 0, check_count = 0, hc = 0;

  always #2 CORE_CLK_I = ~CORE_CLK_I;

  spc_status_prescaler u_dut (.CORE_CLK_I, .RESETN_I, .SFR_ADDR_I, .SFR_WR_I, .SFR_RD_I,
    .SFR_WDATA_I, .SFR_RDATA_O, .TX_DATA_O, .TX_VALID_O, .TX_TAKE_I, .XFER_DONE_I,
    .RX_VALID_I, .RX_DATA_I, .RX_READY_O, .SCK_O, .SCK_EDGE_O, .IRQ_O);
  spc_slave_model u_slave (.clk_i(CORE_CLK_I), .rst_ni(RESETN_I), .flood_i(flood),
    .tx_valid_i(TX_VALID_O), .tx_data_i(TX_DATA_O), .sck_edge_i(SCK_EDGE_O),
    .rx_ready_i(RX_READY_O), .tx_take_o(TX_TAKE_I), .done_o(XFER_DONE_I),
    .rx_valid_o(RX_VALID_I), .rx_data_o(RX_DATA_I));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK_I);
    SFR_ADDR_I <= a;
    SFR_WDATA_I <= d;
    SFR_WR_I <= 1'b1;
    @(posedge CORE_CLK_I);
    SFR_WR_I <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CORE_CLK_I);
    SFR_ADDR_I <= a;
    SFR_RD_I <= 1'b1;
    @(posedge CORE_CLK_I);
    SFR_RD_I <= 1'b0;
    #1 chk(SFR_RDATA_O, exp);
  endtask : rd

  // The model clears the two read-cleared flags after each status read.
  task automatic rdst(input logic bz);
    rd(ADDR_STATUS, {3'h0, bz, tend_m, ovr_m, 1'b1, (rxq.size() > 0)});
    tend_m = 1'b0;
    ovr_m = 1'b0;
  endtask : rdst

  task automatic chk_irq;
    b = {4'h0, tend_m, ovr_m, 1'b1, (rxq.size() > 0)} & en_m;
    chk({7'h00, IRQ_O}, {7'h00, |b});
  endtask : chk_irq

  task automatic xfer(input logic [7:0] d);
    wr(ADDR_TX_DATA, d);
    rd(ADDR_STATUS, {7'h00, (rxq.size() > 0)});
    repeat (4) @(posedge CORE_CLK_I);
    rdst(1'b1);
    for (int i = 0; i < 3000 && !tend_m; i++) begin
      @(posedge CORE_CLK_I);
      #1;
    end
    if (!tend_m) begin
      failures++;
      wrap_up();
    end
    repeat (4) @(posedge CORE_CLK_I);
    #1 chk_irq();
    rdst(1'b0);
    rdst(1'b0);
    b = rxq.pop_front();
    rd(ADDR_RX_DATA, b);
  endtask : xfer

  // Model of the receive path and of the serial clock half period.
  always @(posedge CORE_CLK_I) begin
    if (RESETN_I) begin
      if (RX_VALID_I && RX_READY_O) rxq.push_back(RX_DATA_I);
      if (RX_VALID_I && !RX_READY_O) ovr_m = 1'b1;
      if (XFER_DONE_I) tend_m = 1'b1;
      if (SCK_O) hc++;
      else if (hc != 0) begin
        chk(8'(hc), pre_m >> 1);
        hc = 0;
      end
    end
  end

  initial begin
    {RESETN_I, SFR_WR_I, SFR_RD_I, flood, tend_m, ovr_m} = '0;
    SFR_ADDR_I = 8'h00;
    SFR_WDATA_I = 8'h00;
    pre_m = RST_PRESCALER;
    repeat (3) @(posedge CORE_CLK_I);
    RESETN_I <= 1'b1;
    rd(ADDR_PRESCALER, RST_PRESCALER);
    rd(ADDR_IRQ_ENABLE, RST_IRQ_ENABLE);
    rd(8'hD0, ZERO_BYTE);
    rdst(1'b0);
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      en_m = {4'h0, 4'h1 << (k % 4)};
      wr(ADDR_IRQ_ENABLE, {seed[7:4], en_m[3:0]});
      rd(ADDR_IRQ_ENABLE, en_m);
      pre_m = (seed[15:8] | PRESCALE_W4) & MASK_PRESCALER;
      wr(ADDR_PRESCALER, seed[15:8] | PRESCALE_W4);
      rd(ADDR_PRESCALER, pre_m);
      xfer(seed[23:16]);
    end
    en_m = 8'h04;
    wr(ADDR_IRQ_ENABLE, en_m);
    @(posedge CORE_CLK_I);
    flood <= 1'b1;
    repeat (12) @(posedge CORE_CLK_I);
    flood <= 1'b0;
    #1 chk({7'h00, RX_READY_O}, 8'h00);
    repeat (4) @(posedge CORE_CLK_I);
    #1 chk_irq();
    rdst(1'b0);
    rdst(1'b0);
    for (int n = 0; n < 20 && rxq.size() > 0; n++) begin
      b = rxq.pop_front();
      rd(ADDR_RX_DATA, b);
      repeat (3) @(posedge CORE_CLK_I);
    end
    rdst(1'b0);
    @(posedge CORE_CLK_I);
    RESETN_I <= 1'b0;
    repeat (2) @(posedge CORE_CLK_I);
    pre_m = RST_PRESCALER;
    RESETN_I <= 1'b1;
    rd(ADDR_PRESCALER, RST_PRESCALER);
    rd(ADDR_IRQ_ENABLE, RST_IRQ_ENABLE);
    rdst(1'b0);
    wrap_up();
  end
endmodule : spc_status_prescaler_tb

bind spc_status_prescaler spc_sp_properties u_props (.CORE_CLK_I, .RESETN_I, .SFR_ADDR_I,
  .SFR_WR_I, .SFR_RD_I, .SFR_WDATA_I, .SFR_RDATA_O, .TX_DATA_O, .TX_VALID_O, .TX_TAKE_I,
  .SCK_O, .SCK_EDGE_O, .IRQ_O);
